// [bench/rtk_osc_model.sv]
`default_nettype none
module rtk_osc_model (
  input wire logic ref_clk_i, // System clock
  input wire logic amp_en_i, // Crystal amplifier drive from device
  input wire logic ext_i, // External clock source fitted
  output logic pin_o // Time base pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_r;
  // Crystal swings only while driven; an external source runs on its own
  always_ff @(posedge ref_clk_i) begin
    if (!(amp_en_i || ext_i)) begin
      cnt_r <= 2'h0;
      pin_o <= 1'b0;
    end else if (cnt_r == 2'h2) begin
      cnt_r <= 2'h0;
      pin_o <= ~pin_o;
    end else begin
      cnt_r <= cnt_r + 2'h1;
    end
  end
endmodule
`default_nettype wire

// [bench/rtk_timekeeper_bench.sv]
`default_nettype none
module rtk_timekeeper_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic pin;
  logic pin_out;
  logic amp_en;
  logic ext_r = 1'b0;
  logic wr = 1'b0;
  logic [6:0] wa = 7'h00;
  logic [7:0] wd = 8'h00;
  logic rs = 1'b0;
  logic [6:0] ra = 7'h00;
  logic rn = 1'b0;
  logic [7:0] rdat;
  logic [7:0] v;
  logic [71:0] rv = 72'h00_00_00_01_01_01_01_00_00;
  int fail_count = 0;
  int checks = 0;
  // Clock at 200 MHz
  always #2.5 clk = ~clk;
  rtk_timekeeper #(.TOSF_CYC(50), .PRESCALE(4)) rtk_timekeeper_i (
    .ref_clk_i(clk), .rst_i(rst), .osc_input_pin_i(pin), .osc_output_pin_o(pin_out),
    .osc_output_en_o(amp_en), .wr_i(wr), .wr_addr_i(wa), .wr_data_i(wd),
    .rd_start_i(rs), .rd_addr_i(ra), .rd_next_i(rn), .rd_data_o(rdat));
  rtk_osc_model rtk_osc_model_i (.ref_clk_i(clk), .amp_en_i(amp_en), .ext_i(ext_r),
    .pin_o(pin));
  // Closing report
  task print_verdict;
    $display("mismatches %0d checks %0d", fail_count, checks);
    if (fail_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One register byte written, then a quiet cycle
  task automatic wrb(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    wa <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] q);
    @(posedge clk);
    rs <= 1'b1;
    ra <= a;
    @(posedge clk);
    rs <= 1'b0;
    #1 q = rdat;
  endtask
  task automatic nx(output logic [7:0] q);
    @(posedge clk);
    rn <= 1'b1;
    @(posedge clk);
    rn <= 1'b0;
    #1 q = rdat;
  endtask
  // Poll a byte until masked bits match, bounded
  task automatic wait_byte(input logic [6:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] q;
    for (int i = 0; i < 500; i++) begin
      rd(a, q);
      if ((q & m) === e) return;
    end
    fail_count++;
    $display("BAD t=%0t seen=%h exp=%h", $time, q & m, e);
    print_verdict();
  endtask
  // Load a time one second before a rollover and check the result
  task automatic cal(input logic [7:0] h, d, m, y, eh, ed, em, ey, ew);
    wrb(ADDR7(0), 8'h59);
    wait_byte(7'h03, 8'h20, 8'h00);
    wrb(ADDR7(1), 8'h59);
    wrb(ADDR7(2), h);
    wrb(ADDR7(3), 8'h07);
    wrb(ADDR7(4), d);
    wrb(ADDR7(5), m);
    wrb(ADDR7(6), y);
    wrb(ADDR7(0), 8'hD9);
    wait_byte(7'h00, 8'hFF, 8'h80);
    rd(7'h01, v);
    chk(v, 8'h00);
    nx(v);
    chk(v, eh);
    nx(v);
    chk(v & 8'h07, ew);
    nx(v);
    chk(v, ed);
    nx(v);
    chk(v, em);
    nx(v);
    chk(v, ey);
  endtask
  function automatic logic [6:0] ADDR7(input int a);
    return a[6:0];
  endfunction
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(7'h00, v);
    chk(v, 8'h00);
    for (int i = 1; i < 9; i++) begin
      nx(v);
      chk(v, rv[71-8*i -: 8]);
    end
    cal(8'h23, 8'h31, 8'h12, 8'h99, 8'h00, 8'h01, 8'h21, 8'h00, 8'h01);
    cal(8'h23, 8'h28, 8'h02, 8'h01, 8'h00, 8'h01, 8'h03, 8'h01, 8'h01);
    cal(8'h23, 8'h28, 8'h02, 8'h04, 8'h00, 8'h29, 8'h22, 8'h04, 8'h01);
    cal(8'h23, 8'h30, 8'h04, 8'h05, 8'h00, 8'h01, 8'h05, 8'h05, 8'h01);
    cal(8'h71, 8'h15, 8'h01, 8'h05, 8'h52, 8'h16, 8'h01, 8'h05, 8'h01);
    cal(8'h51, 8'h15, 8'h01, 8'h05, 8'h72, 8'h15, 8'h01, 8'h05, 8'h07);
    wait_byte(7'h03, 8'h20, 8'h20);
    chk({7'h00, amp_en}, 8'h01);
    // Amplifier output is the inverted pin one clock later
    v = {7'h00, ~pin};
    @(posedge clk);
    #1 chk({7'h00, pin_out}, v);
    wrb(7'h00, 8'h00);
    wait_byte(7'h03, 8'h20, 8'h00);
    chk({7'h00, amp_en}, 8'h00);
    rd(7'h00, v);
    chk(v, 8'h00);
    repeat (100) @(posedge clk);
    rd(7'h00, v);
    chk(v, 8'h00);
    ext_r <= 1'b1;
    wrb(7'h07, 8'h08);
    wait_byte(7'h03, 8'h20, 8'h20);
    rd(7'h07, v);
    chk(v, 8'h08);
    chk({7'h00, amp_en}, 8'h00);
    wrb(7'h07, 8'h00);
    wait_byte(7'h03, 8'h20, 8'h00);
    ext_r <= 1'b0;
    // Time base stopped: seconds hold; the wrap must pick up a later write
    wrb(7'h00, 8'h42);
    rd(7'h1F, v);
    chk(v, 8'h00);
    wrb(7'h00, 8'h17);
    wrb(7'h01, 8'h33);
    nx(v);
    chk(v, 8'h17);
    wrb(7'h01, 8'h44);
    nx(v);
    chk(v, 8'h33);
    print_verdict();
  end
endmodule
`default_nettype wire

// [verilog/rtk_osc_mon.sv]
`default_nettype none
module rtk_osc_mon #(
  parameter int RUN_EDGES = rtk_pkg::OSC_RUN_EDGES,
  parameter int TIMEOUT_CYC = rtk_pkg::OSF_TIMEOUT_CYC
) (
  input wire logic ref_clk_i, // System clock
  input wire logic rst_i, // Synchronous reset
  input wire logic edge_i, // One time base cycle seen
  output logic running_o // Oscillator running
);
  localparam int EW = $clog2(RUN_EDGES + 1);
  rtk_pkg::rtk_osc_e state_r;
  logic [EW-1:0] edge_cnt_r;
  logic [31:0] idle_r;
  logic timeout;

  assign timeout = (idle_r == 32'(TIMEOUT_CYC));
  assign running_o = (state_r == rtk_pkg::OSC_RUNNING);

  // Clocks since the last time base edge, saturating at the limit
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || edge_i) begin
      idle_r <= '0;
    end else if (!timeout) begin
      idle_r <= idle_r + 32'h1;
    end
  end

  // Start detection and failure detection
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_r <= rtk_pkg::OSC_STOPPED;
      edge_cnt_r <= '0;
    end else begin
      unique case (state_r)
        rtk_pkg::OSC_STOPPED: begin
          if (edge_i) begin
            state_r <= rtk_pkg::OSC_STARTING;
            edge_cnt_r <= EW'(1);
          end
        end
        rtk_pkg::OSC_STARTING: begin
          if (timeout) begin
            state_r <= rtk_pkg::OSC_STOPPED;
          end else if (edge_i) begin
            edge_cnt_r <= edge_cnt_r + EW'(1);
            if (edge_cnt_r == EW'(RUN_EDGES - 1)) begin
              state_r <= rtk_pkg::OSC_RUNNING;
            end
          end
        end
        rtk_pkg::OSC_RUNNING: begin
          if (timeout) begin
            state_r <= rtk_pkg::OSC_STOPPED;
          end
        end
        default: begin
          state_r <= rtk_pkg::OSC_STOPPED;
        end
      endcase
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  AST_RUN_AFTER_EDGES: assert property (
    (state_r == rtk_pkg::OSC_STARTING && edge_i && !timeout &&
     edge_cnt_r == EW'(RUN_EDGES - 1)) |=> running_o)
    else $error("running flag not set after the start edges");
  AST_RUN_NEEDS_EDGE: assert property ($rose(running_o) |-> $past(edge_i))
    else $error("running flag rose without an edge");
  AST_RUN_DROP: assert property ((running_o && timeout) |=> !running_o)
    else $error("running flag kept after oscillator timeout");
endmodule
`default_nettype wire

// [verilog/rtk_pkg.sv]
`default_nettype none
package rtk_pkg;
  // Register addresses
  localparam logic [6:0] ADDR_SEC = 7'h00;
  localparam logic [6:0] ADDR_MIN = 7'h01;
  localparam logic [6:0] ADDR_HOUR = 7'h02;
  localparam logic [6:0] ADDR_WKDAY = 7'h03;
  localparam logic [6:0] ADDR_DATE = 7'h04;
  localparam logic [6:0] ADDR_MTH = 7'h05;
  localparam logic [6:0] ADDR_YEAR = 7'h06;
  localparam logic [6:0] ADDR_CTRL = 7'h07;
  localparam logic [6:0] RTCC_LAST = 7'h1F;
  localparam logic [6:0] NUM_SNAP = 7'h07;
  // Field positions
  localparam int ST_BIT = 7;
  localparam int FMT_BIT = 6;
  localparam int PM_BIT = 5;
  localparam int EXT_CLOCK_ENABLE_BIT = 3;
  // Reset values
  localparam logic [6:0] RST_SEC = 7'h00;
  localparam logic [6:0] RST_MIN = 7'h00;
  localparam logic [5:0] RST_HOUR = 6'h00;
  localparam logic [2:0] RST_WKDAY = 3'h1;
  localparam logic [5:0] RST_DATE = 6'h01;
  localparam logic [4:0] RST_MTH = 5'h01;
  localparam logic [7:0] RST_YEAR = 8'h01;
  localparam logic [7:0] RST_CTRL = 8'h00;
  // Calendar limits in BCD
  localparam logic [6:0] SEC_LAST = 7'h59;
  localparam logic [6:0] MIN_LAST = 7'h59;
  localparam logic [5:0] H24_LAST = 6'h23;
  localparam logic [4:0] H12_ELEVEN = 5'h11;
  localparam logic [4:0] H12_NOON = 5'h12;
  localparam logic [4:0] H12_ONE = 5'h01;
  localparam logic [2:0] WK_FIRST = 3'h1;
  localparam logic [2:0] WK_LAST = 3'h7;
  localparam logic [5:0] DAY_FIRST = 6'h01;
  localparam logic [5:0] DAY_28 = 6'h28;
  localparam logic [5:0] DAY_29 = 6'h29;
  localparam logic [5:0] DAY_30 = 6'h30;
  localparam logic [5:0] DAY_31 = 6'h31;
  localparam logic [4:0] MTH_FIRST = 5'h01;
  localparam logic [4:0] MTH_FEB = 5'h02;
  localparam logic [4:0] MTH_APR = 5'h04;
  localparam logic [4:0] MTH_JUN = 5'h06;
  localparam logic [4:0] MTH_SEP = 5'h09;
  localparam logic [4:0] MTH_NOV = 5'h11;
  localparam logic [4:0] MTH_LAST = 5'h12;
  localparam logic [7:0] YEAR_LAST = 8'h99;
  // Timing
  localparam int OSC_RUN_EDGES = 32;
  localparam int TB_DIV = 32768;
  localparam int CLK_PERIOD_NS = 5;
  localparam int OSF_TIMEOUT_US = 1000;
  localparam int OSF_TIMEOUT_CYC = (OSF_TIMEOUT_US * 1000) / CLK_PERIOD_NS;
  // Oscillator monitor states
  typedef enum logic [1:0] {OSC_STOPPED, OSC_STARTING, OSC_RUNNING} rtk_osc_e;
endpackage
`default_nettype wire

// [verilog/rtk_prescale.sv]
`default_nettype none
module rtk_prescale #(
  parameter int DIV = rtk_pkg::TB_DIV
) (
  input wire logic ref_clk_i, // System clock
  input wire logic rst_i, // Synchronous reset
  input wire logic clr_i, // Restart the second
  input wire logic edge_i, // One time base cycle seen
  output logic tick_o // One-cycle seconds pulse
);
  localparam int CW = $clog2(DIV);
  logic [CW-1:0] cnt_r;
  logic tick_r;
  logic last;

  assign last = (cnt_r == CW'(DIV - 1));
  assign tick_o = tick_r;

  // Divider advances only on time base edges
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || clr_i) begin
      cnt_r <= '0;
    end else if (edge_i) begin
      cnt_r <= last ? '0 : cnt_r + CW'(1);
    end
  end

  // Seconds pulse
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      tick_r <= 1'b0;
    end else begin
      tick_r <= edge_i && last && !clr_i;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  AST_TICK_CAUSE: assert property (tick_o |-> $past(edge_i) && $past(last))
    else $error("seconds pulse without a full divider count");
  AST_TICK_HOLD: assert property (!edge_i |=> !tick_o)
    else $error("seconds pulse while time base idle");
endmodule
`default_nettype wire

// [verilog/rtk_timekeeper.sv]
`default_nettype none
// Functional notes
// - Time base is a crystal on the oscillator pins or external clock on input pin.
// - Crystal amplifier runs only while the start bit is set.
// - External clock counts as time base while its enable bit or the start bit is set.
// - Running flag sets after 32 time base cycles once the oscillator starts.
// - Running flag clears when no cycles arrive for longer than the fail timeout.
// - Separate BCD registers for seconds, minutes, hours, weekday, date, month, year.
// - Short months handled automatically; leap years corrected from 2001 to 2099.
// - Year is two BCD digits, rolls 99 to 00 with no further carry.
// - Hours kept in 12-hour or 24-hour form per the format bit.
// - Day ends at 11:59:59 PM or 23:59:59, carrying into date and weekday.
// - Weekday counts 1 to 7, advances at midnight, wraps to 1, no carry.
// - After the last day of month 12 comes 01/01 with a year carry.
// - Month lengths 31 or 30 days; February 29 in leap years, else 28.
// - Reads of 0x00 to 0x06 come from a snapshot refreshed when a read starts in 0x00 to 0x1F.
// - Snapshot refreshes again when a read address wraps from 0x1F to 0x00.
// - Format bit set selects 12-hour mode, clear selects 24-hour mode.
// - Read-only leap year flag is one when the current year is leap.
module rtk_timekeeper #(
  parameter int TOSF_CYC = rtk_pkg::OSF_TIMEOUT_CYC, // Fail timeout in clocks
  parameter int PRESCALE = rtk_pkg::TB_DIV // Time base cycles per second
) (
  input wire logic ref_clk_i, // System clock
  input wire logic rst_i, // Synchronous reset
  input wire logic osc_input_pin_i, // Crystal or external clock input
  output logic osc_output_pin_o, // Crystal amplifier output
  output logic osc_output_en_o, // Amplifier drives output pin
  input wire logic wr_i, // Register write strobe
  input wire logic [6:0] wr_addr_i, // Register write address
  input wire logic [7:0] wr_data_i, // Register write data
  input wire logic rd_start_i, // Read begins at rd_addr_i
  input wire logic [6:0] rd_addr_i, // Read start address
  input wire logic rd_next_i, // Advance to next read byte
  output logic [7:0] rd_data_o // Read data
);
  logic st_r, fmt12_r, x1_d_r, x2_r;
  logic [7:0] ctrl_r, yr_r, yr_nxt;
  logic [6:0] sec_r, min_r, sec_nxt, min_nxt;
  logic [5:0] hr_r, date_r, hr_nxt, date_nxt;
  logic [2:0] wk_r, wk_nxt;
  logic [4:0] mon_r, mon_nxt;
  logic src_en, tb_edge, sec_tick, osc_run, adv, leap, refresh;
  logic min_c, hr_c, day_c, mon_c, yr_c;
  logic wr_sec, wr_min, wr_hour, wr_wk, wr_date, wr_mon, wr_year, wr_ctrl;
  logic [7:0] live_b [0:6];
  logic [7:0] snap_r [0:6];
  logic [6:0] rd_ptr_r, rd_ptr_nxt;
  logic [7:0] rd_byte, rd_data_r;

  // BCD increment of a two-digit value
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      return {v[7:4] + 4'h1, 4'h0};
    end
    return {v[7:4], v[3:0] + 4'h1};
  endfunction

  // Leap year within a century: BCD year divisible by four
  function automatic logic is_leap(input logic [7:0] y);
    if (y[4] == 1'b0) begin
      return (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
    end
    return (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
  endfunction

  // Last date of a month
  function automatic logic [5:0] last_day(input logic [4:0] m, input logic lp);
    if (m == rtk_pkg::MTH_FEB) begin
      return lp ? rtk_pkg::DAY_29 : rtk_pkg::DAY_28;
    end
    if (m == rtk_pkg::MTH_APR || m == rtk_pkg::MTH_JUN ||
        m == rtk_pkg::MTH_SEP || m == rtk_pkg::MTH_NOV) begin
      return rtk_pkg::DAY_30;
    end
    return rtk_pkg::DAY_31;
  endfunction

  // Write decode
  assign wr_sec = wr_i && (wr_addr_i == rtk_pkg::ADDR_SEC);
  assign wr_min = wr_i && (wr_addr_i == rtk_pkg::ADDR_MIN);
  assign wr_hour = wr_i && (wr_addr_i == rtk_pkg::ADDR_HOUR);
  assign wr_wk = wr_i && (wr_addr_i == rtk_pkg::ADDR_WKDAY);
  assign wr_date = wr_i && (wr_addr_i == rtk_pkg::ADDR_DATE);
  assign wr_mon = wr_i && (wr_addr_i == rtk_pkg::ADDR_MTH);
  assign wr_year = wr_i && (wr_addr_i == rtk_pkg::ADDR_YEAR);
  assign wr_ctrl = wr_i && (wr_addr_i == rtk_pkg::ADDR_CTRL);

  // Start bit, hour format and configuration byte
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st_r <= 1'b0;
      fmt12_r <= 1'b0;
      ctrl_r <= rtk_pkg::RST_CTRL;
    end else begin
      if (wr_sec) begin
        st_r <= wr_data_i[rtk_pkg::ST_BIT];
      end
      if (wr_hour) begin
        fmt12_r <= wr_data_i[rtk_pkg::FMT_BIT];
      end
      if (wr_ctrl) begin
        ctrl_r <= wr_data_i;
      end
    end
  end

  // Input pin history and inverting crystal amplifier
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      x1_d_r <= 1'b0;
      x2_r <= 1'b0;
    end else begin
      x1_d_r <= osc_input_pin_i;
      x2_r <= ~osc_input_pin_i;
    end
  end

  // Crystal drive only in crystal mode with start set
  assign osc_output_pin_o = x2_r;
  assign osc_output_en_o = st_r && !ctrl_r[rtk_pkg::EXT_CLOCK_ENABLE_BIT];
  assign src_en = ctrl_r[rtk_pkg::EXT_CLOCK_ENABLE_BIT] || st_r;
  assign tb_edge = src_en && osc_input_pin_i && !x1_d_r;

  // Running detector
  rtk_osc_mon #(
    .RUN_EDGES(rtk_pkg::OSC_RUN_EDGES),
    .TIMEOUT_CYC(TOSF_CYC)
  ) u_osc_mon (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .edge_i(tb_edge),
    .running_o(osc_run)
  );

  // Seconds divider, restarted by a seconds write
  rtk_prescale #(
    .DIV(PRESCALE)
  ) u_prescale (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .clr_i(wr_sec),
    .edge_i(tb_edge),
    .tick_o(sec_tick)
  );

  // A tick that meets a host write is dropped
  assign adv = sec_tick && !wr_i;
  assign leap = is_leap(yr_r);

  // Carry chain from seconds to year
  always_comb begin
    logic [7:0] t;
    t = 8'h00;
    sec_nxt = sec_r;
    min_nxt = min_r;
    hr_nxt = hr_r;
    wk_nxt = wk_r;
    date_nxt = date_r;
    mon_nxt = mon_r;
    yr_nxt = yr_r;
    min_c = 1'b0;
    hr_c = 1'b0;
    day_c = 1'b0;
    mon_c = 1'b0;
    yr_c = 1'b0;
    if (adv) begin
      if (sec_r == rtk_pkg::SEC_LAST) begin
        sec_nxt = '0;
        min_c = 1'b1;
      end else begin
        t = bcd_inc({1'b0, sec_r});
        sec_nxt = t[6:0];
      end
    end
    if (min_c) begin
      if (min_r == rtk_pkg::MIN_LAST) begin
        min_nxt = '0;
        hr_c = 1'b1;
      end else begin
        t = bcd_inc({1'b0, min_r});
        min_nxt = t[6:0];
      end
    end
    if (hr_c) begin
      if (fmt12_r) begin
        if (hr_r[4:0] == rtk_pkg::H12_ELEVEN) begin
          hr_nxt = {~hr_r[rtk_pkg::PM_BIT], rtk_pkg::H12_NOON};
          day_c = hr_r[rtk_pkg::PM_BIT];
        end else if (hr_r[4:0] == rtk_pkg::H12_NOON) begin
          hr_nxt = {hr_r[rtk_pkg::PM_BIT], rtk_pkg::H12_ONE};
        end else begin
          t = bcd_inc({3'h0, hr_r[4:0]});
          hr_nxt = {hr_r[rtk_pkg::PM_BIT], t[4:0]};
        end
      end else begin
        if (hr_r == rtk_pkg::H24_LAST) begin
          hr_nxt = '0;
          day_c = 1'b1;
        end else begin
          t = bcd_inc({2'h0, hr_r});
          hr_nxt = t[5:0];
        end
      end
    end
    if (day_c) begin
      wk_nxt = (wk_r == rtk_pkg::WK_LAST) ? rtk_pkg::WK_FIRST : wk_r + 3'h1;
      if (date_r == last_day(mon_r, leap)) begin
        date_nxt = rtk_pkg::DAY_FIRST;
        mon_c = 1'b1;
      end else begin
        t = bcd_inc({2'h0, date_r});
        date_nxt = t[5:0];
      end
    end
    if (mon_c) begin
      if (mon_r == rtk_pkg::MTH_LAST) begin
        mon_nxt = rtk_pkg::MTH_FIRST;
        yr_c = 1'b1;
      end else begin
        t = bcd_inc({3'h0, mon_r});
        mon_nxt = t[4:0];
      end
    end
    if (yr_c) begin
      yr_nxt = (yr_r == rtk_pkg::YEAR_LAST) ? 8'h00 : bcd_inc(yr_r);
    end
  end

  // Time of day registers
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      sec_r <= rtk_pkg::RST_SEC;
      min_r <= rtk_pkg::RST_MIN;
      hr_r <= rtk_pkg::RST_HOUR;
    end else begin
      sec_r <= wr_sec ? wr_data_i[6:0] : sec_nxt;
      min_r <= wr_min ? wr_data_i[6:0] : min_nxt;
      hr_r <= wr_hour ? wr_data_i[5:0] : hr_nxt;
    end
  end

  // Calendar registers
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wk_r <= rtk_pkg::RST_WKDAY;
      date_r <= rtk_pkg::RST_DATE;
      mon_r <= rtk_pkg::RST_MTH;
      yr_r <= rtk_pkg::RST_YEAR;
    end else begin
      wk_r <= wr_wk ? wr_data_i[2:0] : wk_nxt;
      date_r <= wr_date ? wr_data_i[5:0] : date_nxt;
      mon_r <= wr_mon ? wr_data_i[4:0] : mon_nxt;
      yr_r <= wr_year ? wr_data_i : yr_nxt;
    end
  end

  // Live register images with status bits
  assign live_b[0] = {st_r, sec_r};
  assign live_b[1] = {1'b0, min_r};
  assign live_b[2] = {1'b0, fmt12_r, hr_r};
  assign live_b[3] = {2'b00, osc_run, 2'b00, wk_r};
  assign live_b[4] = {2'b00, date_r};
  assign live_b[5] = {2'b00, leap, mon_r};
  assign live_b[6] = yr_r;

  // Read pointer and snapshot refresh events
  assign refresh = (rd_start_i && rd_addr_i <= rtk_pkg::RTCC_LAST) ||
                   (!rd_start_i && rd_next_i && rd_ptr_r == rtk_pkg::RTCC_LAST);
  always_comb begin
    rd_ptr_nxt = rd_ptr_r;
    if (rd_start_i) begin
      rd_ptr_nxt = rd_addr_i;
    end else if (rd_next_i) begin
      rd_ptr_nxt = (rd_ptr_r == rtk_pkg::RTCC_LAST) ? 7'h00 : rd_ptr_r + 7'h01;
    end
  end

  // Byte for the next read slot; a fresh snapshot is read straight from live
  always_comb begin
    rd_byte = 8'h00;
    if (rd_ptr_nxt < rtk_pkg::NUM_SNAP) begin
      rd_byte = refresh ? live_b[rd_ptr_nxt[2:0]] : snap_r[rd_ptr_nxt[2:0]];
    end else if (rd_ptr_nxt == rtk_pkg::ADDR_CTRL) begin
      rd_byte = ctrl_r;
    end
  end

  // Snapshot buffer
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 7; i++) begin
        snap_r[i] <= 8'h00;
      end
    end else if (refresh) begin
      for (int i = 0; i < 7; i++) begin
        snap_r[i] <= live_b[i];
      end
    end
  end

  // Read pointer and read data
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rd_ptr_r <= 7'h00;
      rd_data_r <= 8'h00;
    end else begin
      rd_ptr_r <= rd_ptr_nxt;
      if (rd_start_i || rd_next_i) begin
        rd_data_r <= rd_byte;
      end
    end
  end

  assign rd_data_o = rd_data_r;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_last_min;
    adv && sec_r == rtk_pkg::SEC_LAST && min_r == rtk_pkg::MIN_LAST;
  endsequence
  sequence s_new_day;
    ##1 wk_r != $past(wk_r) && date_r != $past(date_r);
  endsequence

  AST_SEC_WRAP: assert property ((adv && sec_r == rtk_pkg::SEC_LAST) |=>
    sec_r == 7'h00 && min_r != $past(min_r))
    else $error("seconds did not wrap into minutes");
  AST_MIDNIGHT24: assert property ((s_last_min ##0 (!fmt12_r &&
    hr_r == rtk_pkg::H24_LAST)) |-> s_new_day ##0 hr_r == 6'h00)
    else $error("24-hour midnight rollover wrong");
  AST_MIDNIGHT12: assert property ((s_last_min ##0 (fmt12_r &&
    hr_r == {1'b1, rtk_pkg::H12_ELEVEN})) |-> s_new_day ##0 hr_r == {1'b0, rtk_pkg::H12_NOON})
    else $error("12-hour midnight rollover wrong");
  AST_NOON12: assert property ((s_last_min ##0 (fmt12_r &&
    hr_r == {1'b0, rtk_pkg::H12_ELEVEN})) |=> hr_r == {1'b1, rtk_pkg::H12_NOON} && $stable(wk_r))
    else $error("12-hour noon handling wrong");
  AST_WK_WRAP: assert property ((day_c && wk_r == rtk_pkg::WK_LAST) |=>
    wk_r == rtk_pkg::WK_FIRST)
    else $error("weekday did not wrap to one");
  AST_FEB_END: assert property ((day_c && mon_r == rtk_pkg::MTH_FEB && !leap &&
    date_r == rtk_pkg::DAY_28) |=> date_r == rtk_pkg::DAY_FIRST && mon_r != $past(mon_r))
    else $error("February end wrong in a common year");
  AST_NEW_YEAR: assert property ((day_c && mon_r == rtk_pkg::MTH_LAST &&
    date_r == rtk_pkg::DAY_31) |=> mon_r == rtk_pkg::MTH_FIRST &&
    date_r == rtk_pkg::DAY_FIRST && yr_r != $past(yr_r))
    else $error("new year rollover wrong");
  AST_YEAR_WRAP: assert property ((yr_c && yr_r == rtk_pkg::YEAR_LAST) |=> yr_r == 8'h00)
    else $error("year did not wrap to zero");
  AST_SNAP_START: assert property ((rd_start_i && rd_addr_i == rtk_pkg::ADDR_SEC) |=>
    rd_data_o == $past(live_b[0]))
    else $error("read start did not return fresh seconds");
  AST_SNAP_WRAP: assert property ((rd_next_i && !rd_start_i &&
    rd_ptr_r == rtk_pkg::RTCC_LAST) |=> rd_data_o == $past(live_b[0]))
    else $error("address wrap did not refresh snapshot");
  AST_TB_GATE: assert property ((!st_r && !ctrl_r[rtk_pkg::EXT_CLOCK_ENABLE_BIT]) |-> ##1 !sec_tick)
    else $error("seconds advanced with time base disabled");
endmodule
`default_nettype wire
